// ===== common/pff_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
// pin samples from the synchroniser into the edge detector
interface pff_edge_if;
  logic [7:0] level; // settled pin levels
  logic [7:0] rise; // one-cycle rising pulse
  logic [7:0] fall; // one-cycle falling pulse
  modport sync (output level, output rise, output fall);
  modport core (input level, input rise, input fall);
endinterface
`default_nettype wire

// ===== common/pff_pkg.sv
package pff_pkg;

  // ---------------------------------------------------------------
  // register map (word indices on the plain register port)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_LATCH = 4'h0; // output latch
  localparam logic [3:0] ADDR_PINS = 4'h1; // pin levels, read only
  localparam logic [3:0] ADDR_DIR = 4'h2; // direction
  localparam logic [3:0] ADDR_FUNC = 4'h3; // function select, 16 bits
  localparam logic [3:0] ADDR_EDGE = 4'h4; // edge flags
  localparam logic [3:0] ADDR_LEVEL = 4'h5; // programmable request level
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h6; // sticky event status
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h7; // event mask

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] PIN_MASK = 8'h87; // bits 7, 2, 1, 0 are real pins
  localparam logic [7:0] DIR_RESET = 8'h00; // all pins start as inputs
  localparam logic [15:0] FUNC_RESET_MUX = 16'hFFFC; // pin 0 field = 00
  localparam logic [15:0] FUNC_RESET_NONMUX = 16'hFFFF;
  localparam logic [2:0] LEVEL_RESET = 3'h1; // request level after reset
  localparam logic [2:0] LEVEL_BUS_ERR = 3'h0; // level 0 turns pin 1 to bus error
  localparam logic [7:0] ZERO8 = 8'h00;

  // function field encodings
  localparam logic [1:0] FN_EDGE_IRQ = 2'h0;
  localparam logic [1:0] FN_RISE = 2'h1;
  localparam logic [1:0] FN_FALL = 2'h2;
  localparam logic [1:0] FN_LEVEL_IRQ = 2'h3;

  // pin positions
  localparam int BIT_ALE = 0;
  localparam int BIT_PROG = 1;
  localparam int BIT_FIX2 = 2;
  localparam int BIT_FIX7 = 7;

endpackage

// ===== dv/pff_board.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// board model on the port pins
// ----
module pff_board (
  // port side
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_n,
  // board drive and its enables
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  // resolved levels
  output logic [7:0] pin_i
);
  // the port wins where it drives; a pull-up lifts any line nobody drives
  assign pin_i = (~pin_oe_n & pin_o) | (pin_oe_n & ((ext_en & ext_val) | ~ext_en));
endmodule
`default_nettype wire

// ===== dv/pff_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// port checker
// ----
module pff_port_chk (
  // clock and resets
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic por_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // pins and requests
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_n,
  input wire logic programmable_level_request,
  input wire logic [2:0] programmable_request_level,
  input wire logic bus_error_input,
  input wire logic [7:0] edge_irq_event
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // level write shows on the next edge
  property level_wr_p;
    reg_wr && reg_addr == 4'h5 |-> ##1 programmable_request_level == $past(reg_wdata[2:0]);
  endproperty
  oe_reset_a: assert property (disable iff (1'b0) !rst_n |-> pin_oe_n == 8'hFF) else $error("driver on in reset");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("stray read data");
  rsvd_read_a: assert property ($past(reg_rd) && $past(reg_addr) <= 4'h2 |-> (reg_rdata & 16'hFF78) == 16'h0000) else $error("reserved bits read");
  // latch output may only move after a latch write, or two cycles after rst_n was low
  latch_hold_a: assert property (disable iff (!por_n || !rst_n) $changed(pin_o)
    |-> $past(reg_wr && reg_addr == 4'h0) || $past(reg_wr && reg_addr == 4'h0, 2) || !$past(rst_n, 2))
    else $error("latch moved");
  rsvd_drive_a: assert property ((pin_oe_n & 8'h78) == 8'h78 && pin_o[6:3] == 4'h0) else $error("reserved pin driven");
  level_wr_a: assert property (level_wr_p) else $error("level not taken");
  fault_lvl_a: assert property (bus_error_input |-> programmable_request_level == 3'h0
    || $past(programmable_request_level) == 3'h0 || $past(programmable_request_level, 2) == 3'h0)
    else $error("bus error at nonzero level");
  req_lvl_a: assert property (programmable_level_request |-> programmable_request_level != 3'h0
    || $past(programmable_request_level) != 3'h0) else $error("request at level zero");
  rsvd_event_a: assert property (edge_irq_event[6:3] == 4'h0) else $error("reserved event");
  // main scenarios reached
  cover property (edge_irq_event != 8'h00);
  cover property (bus_error_input);
  cover property (programmable_level_request);
endmodule
bind pff_port pff_port_chk pff_port_chk_i (.sys_clk(sys_clk), .rst_n(rst_n), .por_n(por_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_o(pin_o),
  .pin_oe_n(pin_oe_n), .programmable_level_request(programmable_level_request),
  .programmable_request_level(programmable_request_level), .bus_error_input(bus_error_input),
  .edge_irq_event(edge_irq_event));
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ----
  // stimulus and observation
  // ----
  logic sys_clk = 1'b0;
  logic rst_n = 1'b1;
  logic por_n = 1'b1;
  logic mux_bus_cfg = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, rv;
  logic [7:0] pin_i, pin_o, pin_oe_n, ev;
  logic [7:0] ext_val = 8'hFF;
  logic [7:0] ext_en = 8'h00;
  logic l7, l2, preq, buserr, irq;
  logic [2:0] plvl;
  int errors = 0;
  int samples_checked = 0;
  int n2 = 0; // edge-mode request pulses
  int ne = 0; // cycles with an edge event
  always #4 sys_clk = ~sys_clk;
  // pulses last one cycle, so they are counted rather than sampled
  always @(posedge sys_clk)
  begin
    n2 += int'(l2);
    ne += int'(ev != 8'h00);
  end
  pff_port pff_port_i (.sys_clk(sys_clk), .rst_n(rst_n), .por_n(por_n), .mux_bus_cfg(mux_bus_cfg),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .fixed_level7_request(l7), .fixed_level2_request(l2),
    .programmable_level_request(preq), .programmable_request_level(plvl), .bus_error_input(buserr),
    .edge_irq_event(ev), .irq(irq));
  pff_board pff_board_i (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext_val(ext_val), .ext_en(ext_en), .pin_i(pin_i));
  // ----
  // shared tasks
  // ----
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    chk(rv, exp);
  endtask
  // drive the board, then wait out synchroniser and flag latency
  task automatic drv(input logic [7:0] v, input logic [7:0] en);
    @(posedge sys_clk);
    ext_val <= v;
    ext_en <= en;
    repeat (8) @(posedge sys_clk);
    #1;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset;
    rc(4'h2, 16'h0000);
    rc(4'h3, 16'hFFFC);
    rc(4'h5, 16'h0001);
  endtask
  task automatic t_latch;
    wr(4'h0, 16'hFFFF);
    wr(4'h2, 16'h0087);
    rc(4'h0, 16'h0087);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    mux_bus_cfg <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rc(4'h0, 16'h0087);
    rc(4'h2, 16'h0000);
    rc(4'h3, 16'hFFFF);
  endtask
  task automatic t_dir;
    wr(4'h3, 16'h5555);
    wr(4'h0, 16'h0005);
    drv(8'h82, 8'h87);
    rc(4'h1, 16'h0082);
    drv(8'h00, 8'h00);
    wr(4'h2, 16'h0087);
    drv(8'h00, 8'h00);
    chk(16'(pin_oe_n), 16'h0078);
    rc(4'h1, 16'h0005);
    wr(4'h1, 16'hFFFF);
    rc(4'h2, 16'h0087);
    rc(4'h1, 16'h0005);
    wr(4'h2, 16'h0000);
    drv(8'h00, 8'h00);
  endtask
  task automatic t_edge;
    wr(4'h3, 16'h801C);
    wr(4'h7, 16'h0004);
    rc(4'h4, 16'h0087);
    wr(4'h4, 16'h0000);
    wr(4'h6, 16'h00FF);
    ne = 0;
    drv(8'h00, 8'h87);
    rc(4'h4, 16'h0080);
    chk(16'(irq), 16'h0000);
    chk(16'(preq), 16'h0001);
    drv(8'h04, 8'h87);
    rc(4'h4, 16'h0084);
    chk(16'(irq), 16'h0001);
    chk(16'(ne), 16'h0002);
    wr(4'h4, 16'h0080);
    rc(4'h4, 16'h0080);
    wr(4'h6, 16'h0004);
    drv(8'h04, 8'h87);
    chk(16'(irq), 16'h0000);
    drv(8'h00, 8'h87);
    drv(8'h04, 8'h87);
    wr(4'h4, 16'h0000);
    rc(4'h4, 16'h0004);
    wr(4'h4, 16'h0000);
  endtask
  task automatic t_req;
    wr(4'h3, 16'hC00C);
    drv(8'h04, 8'h87);
    chk(16'(l7), 16'h0001);
    n2 = 0;
    drv(8'h00, 8'h87);
    drv(8'h04, 8'h87);
    chk(16'(n2), 16'h0001);
    rc(4'h4, 16'h0000);
    wr(4'h5, 16'h0000);
    drv(8'h04, 8'h87);
    chk(16'(buserr), 16'h0001);
    chk(16'(preq), 16'h0000);
    wr(4'h5, 16'h0003);
    drv(8'h04, 8'h87);
    chk(16'(plvl), 16'h0003);
    chk(16'(preq), 16'h0001);
    chk(16'(buserr), 16'h0000);
    drv(8'hFF, 8'h00);
    chk(16'(l7), 16'h0000);
  endtask
  // ----
  // verdict and main sequence
  // ----
  task automatic conclude;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    // drop both resets at time zero so the asynchronous branches act before the first edge
    rst_n <= 1'b0;
    por_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    por_n <= 1'b1;
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_reset;
    t_latch;
    t_dir;
    t_edge;
    t_req;
    conclude;
  end
  // a hang counts as a mismatch
  initial
  begin
    #200000;
    errors++;
    conclude;
  end
endmodule
`default_nettype wire

// ===== src/pff_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage pin synchroniser with edge pulses
module pff_pin_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // raw pins
  input wire logic [7:0] pin_i,
  // settled levels and edges
  pff_edge_if.sync eo
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] s1; // first stage, read only by s2
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] lvl; // accepted level
  } pff_sync_t;

  pff_sync_t st_ff;
  pff_sync_t nxt_st;

  // a change counts once stages two and three agree; edge vs prior accepted
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = pin_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < 8; i++)
    begin
      if (st_ff.s2[i] == st_ff.s3[i])
      begin
        nxt_st.lvl[i] = st_ff.s3[i];
      end
    end
  end

  // register the state
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // idle level of the pulled-up pins, so no false edge or request follows reset
      st_ff <= '1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // edges compare new accepted level with previous one
  always_comb
  begin
    eo.level = st_ff.lvl;
    eo.rise = nxt_st.lvl & ~st_ff.lvl;
    eo.fall = ~nxt_st.lvl & st_ff.lvl;
  end

endmodule
`default_nettype wire

// ===== src/pff_port.sv
// Contract
// - latch holds driven levels, reads return latch
// - only power-on reset touches the latch
// - pin register reads live pin levels
// - writes to pin register are ignored
// - direction one drives, zero is input
// - any reset clears all direction bits; here only rst_n does, por_n alone leaves them
// - eight two-bit function fields, four pinned
// - 01 rising, 10 falling edge-detect I/O
// - 11 level interrupts; pin 0 plain I/O
// - 00 edge interrupts; pin 0 plain I/O
// - level zero makes pin 1 bus error
// - function reset all ones, pin0 per mux
// - edge flags only on edge-detect pins
// - clear flag by read then zero write
// - nonzero level: pin 1 requests at level
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pff_port (
  // clock and resets
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic por_n,
  // reset strap: multiplexed bus configuration
  input wire logic mux_bus_cfg,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // pins: input, output, output enable (low = driving)
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_n,
  // pin functions toward the interrupt controller
  output logic fixed_level7_request,
  output logic fixed_level2_request,
  output logic programmable_level_request,
  output logic [2:0] programmable_request_level,
  output logic bus_error_input,
  output logic [7:0] edge_irq_event,
  output logic irq
);

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  pff_edge_if edge_bus ();

  pff_pin_sync u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_i(pin_i),
    .eo(edge_bus.sync)
  );

  // ---------------------------------------------------------------
  // latch: kept in its own process so that only por_n reaches it
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] latch;
  } pff_latch_t;

  pff_latch_t lat_ff;
  pff_latch_t nxt_lat;

  // ---------------------------------------------------------------
  // main state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] dir;
    logic [15:0] func;
    logic [7:0] edge_flags;
    logic [7:0] flags_seen; // flags read as set since last write
    logic [2:0] level;
    logic [7:0] stat;
    logic [7:0] mask;
    logic [15:0] rdata;
    logic [7:0] pin_o;
    logic [7:0] pin_oe_n;
    logic req7;
    logic req2;
    logic reqx;
    logic bus_err; // registered bus error level
    logic [7:0] evt;
    logic irq;
    logic cfg_done; // strap sampled after reset release
  } pff_state_t;

  pff_state_t st_ff;
  pff_state_t nxt_st;

  // field n sits at bits 2n+1:2n
  function automatic logic [1:0] field_of(input logic [15:0] f, input int n);
    field_of = f[2 * n +: 2];
  endfunction

  // pin used as edge-detect I/O (01 or 10)
  function automatic logic is_edge_io(input logic [15:0] f, input int n);
    logic [1:0] v;
    v = field_of(f, n);
    is_edge_io = (v == pff_pkg::FN_RISE) || (v == pff_pkg::FN_FALL);
  endfunction

  // pin serves as general I/O for the latch and direction bits
  function automatic logic is_io(input logic [15:0] f, input int n, input logic [2:0] lvl);
    logic io;
    io = is_edge_io(f, n);
    if (n == pff_pkg::BIT_ALE)
    begin
      io = 1'b1; // pin 0 is I/O for every field value
    end
    if ((n == pff_pkg::BIT_PROG) && (lvl == pff_pkg::LEVEL_BUS_ERR))
    begin
      io = 1'b0; // bus error overrides the field
    end
    is_io = io;
  endfunction

  logic wr_latch;
  logic wr_dir;
  logic wr_func;
  logic wr_edge;
  logic wr_level;
  logic wr_stat;
  logic wr_mask;
  logic [7:0] edge_set;
  logic [7:0] new_flags;

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  // address decode; index 1 (pins) has no write strobe at all
  always_comb
  begin
    wr_latch = reg_wr && (reg_addr == pff_pkg::ADDR_LATCH);
    wr_dir = reg_wr && (reg_addr == pff_pkg::ADDR_DIR);
    wr_func = reg_wr && (reg_addr == pff_pkg::ADDR_FUNC);
    wr_edge = reg_wr && (reg_addr == pff_pkg::ADDR_EDGE);
    wr_level = reg_wr && (reg_addr == pff_pkg::ADDR_LEVEL);
    wr_stat = reg_wr && (reg_addr == pff_pkg::ADDR_IRQ_STAT);
    wr_mask = reg_wr && (reg_addr == pff_pkg::ADDR_IRQ_MASK);
  end

  // latch next value; writes to the pin register never reach it
  always_comb
  begin
    nxt_lat = lat_ff;
    if (wr_latch)
    begin
      nxt_lat.latch = reg_wdata[7:0] & pff_pkg::PIN_MASK;
    end
  end

  // latch reset only by power-on reset; other resets leave it
  always_ff @(posedge sys_clk or negedge por_n)
  begin
    if (!por_n)
    begin
      lat_ff <= '0;
    end
    else
    begin
      lat_ff <= nxt_lat;
    end
  end

  // ---------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------
  // edges are judged on the settled level, so a bouncing pin flags only once it holds
  // selected edges on edge-detect pins, any direction
  always_comb
  begin
    edge_set = pff_pkg::ZERO8;
    for (int i = 0; i < 8; i++)
    begin
      if (pff_pkg::PIN_MASK[i] && is_edge_io(st_ff.func, i))
      begin
        if (field_of(st_ff.func, i) == pff_pkg::FN_RISE)
        begin
          edge_set[i] = edge_bus.rise[i];
        end
        else
        begin
          edge_set[i] = edge_bus.fall[i];
        end
      end
    end
    // pin 1 as bus error or interrupt sets no flag
    if (st_ff.level == pff_pkg::LEVEL_BUS_ERR)
    begin
      edge_set[pff_pkg::BIT_PROG] = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // main next-state logic
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.evt = pff_pkg::ZERO8;

    // strap is caught one cycle after reset release
    if (!st_ff.cfg_done)
    begin
      nxt_st.cfg_done = 1'b1;
      nxt_st.func = mux_bus_cfg ? pff_pkg::FUNC_RESET_MUX : pff_pkg::FUNC_RESET_NONMUX;
    end
    else if (wr_func)
    begin
      nxt_st.func = reg_wdata; // eight fields
    end

    if (wr_dir)
    begin
      nxt_st.dir = reg_wdata[7:0] & pff_pkg::PIN_MASK;
    end
    if (wr_level)
    begin
      nxt_st.level = reg_wdata[2:0];
    end
    if (wr_mask)
    begin
      nxt_st.mask = reg_wdata[7:0] & pff_pkg::PIN_MASK;
    end

    // a read remembers which flags were seen set
    if (reg_rd && (reg_addr == pff_pkg::ADDR_EDGE))
    begin
      nxt_st.flags_seen = st_ff.edge_flags;
    end

    // zero write clears only flags that were read set; new edge wins
    new_flags = st_ff.edge_flags;
    if (wr_edge)
    begin
      new_flags = st_ff.edge_flags & ~(st_ff.flags_seen & ~reg_wdata[7:0]);
      nxt_st.flags_seen = pff_pkg::ZERO8;
    end
    nxt_st.edge_flags = new_flags | edge_set;
    nxt_st.evt = edge_set;

    // sticky status, write one to clear, set beats clear
    if (wr_stat)
    begin
      nxt_st.stat = st_ff.stat & ~reg_wdata[7:0];
    end
    nxt_st.stat = nxt_st.stat | edge_set;
    nxt_st.irq = |(nxt_st.stat & nxt_st.mask);

    // read data, unmapped reads zero
    nxt_st.rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        pff_pkg::ADDR_LATCH: nxt_st.rdata[7:0] = lat_ff.latch;
        pff_pkg::ADDR_PINS: nxt_st.rdata[7:0] = edge_bus.level & pff_pkg::PIN_MASK;
        pff_pkg::ADDR_DIR: nxt_st.rdata[7:0] = st_ff.dir;
        pff_pkg::ADDR_FUNC: nxt_st.rdata = st_ff.func;
        pff_pkg::ADDR_EDGE: nxt_st.rdata[7:0] = st_ff.edge_flags;
        pff_pkg::ADDR_LEVEL: nxt_st.rdata[2:0] = st_ff.level;
        pff_pkg::ADDR_IRQ_STAT: nxt_st.rdata[7:0] = st_ff.stat;
        pff_pkg::ADDR_IRQ_MASK: nxt_st.rdata[7:0] = st_ff.mask;
        default: nxt_st.rdata = '0;
      endcase
    end

    // pin drivers: direction one drives when pin is I/O
    for (int i = 0; i < 8; i++)
    begin
      nxt_st.pin_o[i] = lat_ff.latch[i];
      nxt_st.pin_oe_n[i] = ~(pff_pkg::PIN_MASK[i] && st_ff.dir[i]
                             && is_io(st_ff.func, i, st_ff.level));
    end

    // interrupt request inputs, active low pins; 00 edge, 11 level
    nxt_st.req7 = 1'b0;
    nxt_st.req2 = 1'b0;
    nxt_st.reqx = 1'b0;
    case (field_of(st_ff.func, pff_pkg::BIT_FIX7))
      pff_pkg::FN_LEVEL_IRQ: nxt_st.req7 = ~edge_bus.level[pff_pkg::BIT_FIX7];
      pff_pkg::FN_EDGE_IRQ: nxt_st.req7 = edge_bus.fall[pff_pkg::BIT_FIX7];
      default: nxt_st.req7 = 1'b0;
    endcase
    case (field_of(st_ff.func, pff_pkg::BIT_FIX2))
      pff_pkg::FN_LEVEL_IRQ: nxt_st.req2 = ~edge_bus.level[pff_pkg::BIT_FIX2];
      pff_pkg::FN_EDGE_IRQ: nxt_st.req2 = edge_bus.fall[pff_pkg::BIT_FIX2];
      default: nxt_st.req2 = 1'b0;
    endcase
    // pin 1: bus error at level zero, else request at that level
    nxt_st.bus_err = 1'b0;
    if (st_ff.level == pff_pkg::LEVEL_BUS_ERR)
    begin
      nxt_st.bus_err = ~edge_bus.level[pff_pkg::BIT_PROG];
    end
    else
    begin
      case (field_of(st_ff.func, pff_pkg::BIT_PROG))
        pff_pkg::FN_LEVEL_IRQ: nxt_st.reqx = ~edge_bus.level[pff_pkg::BIT_PROG];
        pff_pkg::FN_EDGE_IRQ: nxt_st.reqx = edge_bus.fall[pff_pkg::BIT_PROG];
        default: nxt_st.reqx = 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // main register; rst_n clears direction and sets level one
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
      st_ff.dir <= pff_pkg::DIR_RESET;
      st_ff.func <= pff_pkg::FUNC_RESET_NONMUX;
      st_ff.level <= pff_pkg::LEVEL_RESET;
      st_ff.pin_oe_n <= '1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata = st_ff.rdata;
  assign pin_o = st_ff.pin_o;
  assign pin_oe_n = st_ff.pin_oe_n;
  assign fixed_level7_request = st_ff.req7;
  assign fixed_level2_request = st_ff.req2;
  assign programmable_level_request = st_ff.reqx;
  assign programmable_request_level = st_ff.level;
  assign bus_error_input = st_ff.bus_err;
  assign edge_irq_event = st_ff.evt;
  assign irq = st_ff.irq;

endmodule
`default_nettype wire
